//--- rtl/csmt_regs.vh
`ifndef CSMT_REGS_VH
`define CSMT_REGS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CSMT_OFF_MODE_CTL 8'h00
`define CSMT_OFF_STATE 8'h04
`define CSMT_OFF_IRQ_EN 8'h14
`define CSMT_OFF_IRQ_MASK 8'h18

// ----------------------------------------------------------------
// Field positions of can_state_flags
// ----------------------------------------------------------------
`define CSMT_B_RX_LEVEL 11
`define CSMT_B_RX_LAST 10
`define CSMT_B_RECEIVING 9
`define CSMT_B_TRANSMITTING 8
`define CSMT_B_SLEEP_FLAG 4
`define CSMT_B_WAKE_FLAG 3
`define CSMT_B_ERR_FLAG 2
`define CSMT_B_SLEEP_STATE 1
`define CSMT_B_INIT_STATE 0

// ----------------------------------------------------------------
// Field positions of mode_control_reg and irq_enable_reg
// ----------------------------------------------------------------
`define CSMT_B_INIT_REQ 0
`define CSMT_B_SLEEP_REQ 1
`define CSMT_B_AUTO_WAKE 5
`define CSMT_B_WARN_EN 8
`define CSMT_B_PASSIVE_EN 9
`define CSMT_B_BUSOFF_EN 10
`define CSMT_B_CODE_EN 11

// ----------------------------------------------------------------
// Reset values, timing counts and error code range
// ----------------------------------------------------------------
`define CSMT_RST_STATE 32'h00000c02
`define CSMT_RST_MODE_CTL 32'h00000002
`define CSMT_IDLE_BITS 11
`define CSMT_CODE_MIN 3'h1
`define CSMT_CODE_MAX 3'h6

`endif

//--- rtl/csmt_sync.v
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Two-stage synchroniser for one level
// ----------------------------------------------------------------
module csmt_sync
#(
   parameter RESET_LEVEL = 1'b1
)
(
   input wire clk,     // Sampling clock
   input wire reset_n, // Asynchronous reset
   input wire ce,      // Clock enable
   input wire d,       // Asynchronous level
   output reg q        // Synchronised level
);

   reg meta;

   // First stage feeds only the second; reset to the idle level
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta <= RESET_LEVEL;
         q <= RESET_LEVEL;
      end
      else if (ce)
      begin
         meta <= d;
         q <= meta;
      end
   end

endmodule

//--- rtl/csmt_top.v
// Behaviour
// - Bit 11 shows the receive line level, bit 10 its last bit sample.
// - Bit 9 is high exactly while the controller is receiving.
// - Bit 8 is high exactly while the controller is transmitting.
// - Bit 4 sets on sleep entry, clears when out of sleep or on write 1.
// - Bit 3 sets on bus activity during sleep and clears on write 1.
// - Bit 2 sets on bus-off, passive or warning with its own enable.
// - Bit 2 also sets on error code 1..6 with its enable; write 1 clears.
// - Bit 1 sets on sleep entry, which from normal waits for frame end.
// - Bit 1 clears on leaving sleep by request drop or auto wakeup.
// - Leaving sleep for normal needs 11 recessive bits before bit 1 drops.
// - Bit 0 sets on init entry, which from normal waits for frame end.
// - Bit 0 clears after 11 recessive bits once init is dropped, or at once if sleep is also requested.
// - With auto wake set, bus activity ends sleep and drops the request.
// - A sleep request from normal waits for the current frame to end.
`timescale 1ns/1ps
`include "csmt_regs.vh"

module csmt_top
(
   input wire CLK,            // 20 MHz peripheral clock
   input wire RESET_N,        // Asynchronous reset, active low
   input wire CE,             // Clock enable, freezes all state when low
   input wire [7:0] ADDR,     // Register byte address
   input wire [31:0] WDATA,   // Write data
   input wire WR,             // Write strobe
   input wire RD,             // Read strobe
   output reg [31:0] RDATA,   // Read data, valid the cycle after RD
   output wire IRQ,           // Level interrupt
   input wire RX_PIN,         // Receive pin from the transceiver
   input wire BIT_SAMPLE,     // Pulse at each bit sample point
   input wire CORE_RX_ACTIVE, // Bit engine is receiving a frame
   input wire CORE_TX_ACTIVE, // Bit engine is transmitting a frame
   input wire BUS_OFF,        // bus_off_flag from the error counters
   input wire PASSIVE,        // passive_error_flag
   input wire WARNING,        // warning_level_flag
   input wire [2:0] ERR_CODE, // error_code_field
   output wire INIT_MODE,     // Controller held in initialisation
   output wire SLEEP_MODE     // Controller held in sleep
);

   // ----------------------------------------------------------------
   // Working mode states
   // ----------------------------------------------------------------
   localparam [2:0] ST_NORMAL = 3'h0;
   localparam [2:0] ST_INIT = 3'h1;
   localparam [2:0] ST_SLEEP = 3'h2;
   localparam [2:0] ST_INIT_EXIT = 3'h3;
   localparam [2:0] ST_SLEEP_EXIT = 3'h4;

   // ----------------------------------------------------------------
   // Address decode helper, shared by read and write paths
   // ----------------------------------------------------------------
   function hit;
      input [7:0] addr;
      input [7:0] off;
      begin
         hit = (addr == off);
      end
   endfunction

   reg [2:0] state;
   reg [2:0] next_state;
   reg [3:0] idle_count;
   reg init_request;
   reg sleep_request;
   reg auto_wake_on_activity;
   reg bus_off_irq_en;
   reg passive_irq_en;
   reg warning_irq_en;
   reg error_code_irq_en;
   reg [2:0] irq_mask;
   reg sleep_entered_flag;
   reg wakeup_flag;
   reg error_event_flag;
   reg rx_last_sample;
   reg rx_prev;
   wire rx_line_level;
   wire frame_idle;
   wire activity;
   wire error_event;
   wire code_hit;
   wire wr_ctl;
   wire wr_state;
   wire wr_en;
   wire wr_mask;
   wire enter_sleep;
   wire wake_auto;
   wire idle_done;
   wire sleep_state_bit;
   wire init_state_bit;
   wire [31:0] state_word;

   // ----------------------------------------------------------------
   // Receive pin path
   // ----------------------------------------------------------------

   // Pin is asynchronous; idle level is recessive (high)
   csmt_sync #(.RESET_LEVEL(1'b1)) u_rx_sync
   (
      .clk(CLK),
      .reset_n(RESET_N),
      .ce(CE),
      .d(RX_PIN),
      .q(rx_line_level)
   );

   // Last sample and edge history, both taken from the synced level
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rx_last_sample <= 1'b1;
         rx_prev <= 1'b1;
      end
      else if (CE)
      begin
         rx_prev <= rx_line_level;
         if (BIT_SAMPLE)
            rx_last_sample <= rx_line_level;
      end
   end

   // A recessive-to-dominant edge counts as bus activity
   assign activity = rx_prev & ~rx_line_level;

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------

   // Only whole-word writes exist on this port, so no lane masking
   assign wr_ctl = WR & hit(ADDR, `CSMT_OFF_MODE_CTL);
   assign wr_state = WR & hit(ADDR, `CSMT_OFF_STATE);
   assign wr_en = WR & hit(ADDR, `CSMT_OFF_IRQ_EN);
   assign wr_mask = WR & hit(ADDR, `CSMT_OFF_IRQ_MASK);

   // ----------------------------------------------------------------
   // Mode control and enable registers
   // ----------------------------------------------------------------

   // Auto wakeup drops the sleep request itself; hardware beats software
   // so a wake in the same cycle as a write is never lost
   assign wake_auto = activity & auto_wake_on_activity &
                      (state == ST_SLEEP);
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         init_request <= 1'b0;
         sleep_request <= 1'b1;
         auto_wake_on_activity <= 1'b0;
         bus_off_irq_en <= 1'b0;
         passive_irq_en <= 1'b0;
         warning_irq_en <= 1'b0;
         error_code_irq_en <= 1'b0;
         irq_mask <= 3'h0;
      end
      else if (CE)
      begin
         if (wr_ctl)
         begin
            init_request <= WDATA[`CSMT_B_INIT_REQ];
            sleep_request <= WDATA[`CSMT_B_SLEEP_REQ];
            auto_wake_on_activity <= WDATA[`CSMT_B_AUTO_WAKE];
         end
         if (wake_auto)
            sleep_request <= 1'b0;
         if (wr_en)
         begin
            warning_irq_en <= WDATA[`CSMT_B_WARN_EN];
            passive_irq_en <= WDATA[`CSMT_B_PASSIVE_EN];
            bus_off_irq_en <= WDATA[`CSMT_B_BUSOFF_EN];
            error_code_irq_en <= WDATA[`CSMT_B_CODE_EN];
         end
         if (wr_mask)
            irq_mask <= WDATA[`CSMT_B_SLEEP_FLAG:`CSMT_B_ERR_FLAG];
      end
   end

   // ----------------------------------------------------------------
   // Recessive bit counter for leaving init or sleep
   // ----------------------------------------------------------------

   // Any dominant sample restarts the run; counting only in exit states
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         idle_count <= 4'h0;
      else if (CE)
      begin
         if (state != ST_INIT_EXIT && state != ST_SLEEP_EXIT)
            idle_count <= 4'h0;
         else if (BIT_SAMPLE)
         begin
            if (!rx_line_level)
               idle_count <= 4'h0;
            else if (!idle_done)
               idle_count <= idle_count + 4'h1;
         end
      end
   end

   assign idle_done = (idle_count == `CSMT_IDLE_BITS);

   // ----------------------------------------------------------------
   // Working mode state machine
   // ----------------------------------------------------------------

   // Mode changes out of normal must not cut a frame in half
   assign frame_idle = ~CORE_RX_ACTIVE & ~CORE_TX_ACTIVE;

   always @*
   begin
      next_state = state;
      case (state)
         ST_NORMAL:
         begin
            if (init_request & frame_idle)
               next_state = ST_INIT;
            else if (sleep_request & frame_idle)
               next_state = ST_SLEEP;
         end
         ST_INIT:
         begin
            if (!init_request)
            begin
               if (sleep_request)
                  next_state = ST_SLEEP;
               else
                  next_state = ST_INIT_EXIT;
            end
         end
         ST_INIT_EXIT:
         begin
            if (init_request)
               next_state = ST_INIT;
            else if (idle_done)
               next_state = ST_NORMAL;
         end
         ST_SLEEP:
         begin
            if (init_request & ~sleep_request)
               next_state = ST_INIT;
            else if (~sleep_request | wake_auto)
               next_state = ST_SLEEP_EXIT;
         end
         ST_SLEEP_EXIT:
         begin
            if (sleep_request & ~wake_auto)
               next_state = ST_SLEEP;
            else if (init_request)
               next_state = ST_INIT;
            else if (idle_done)
               next_state = ST_NORMAL;
         end
         default:
            next_state = ST_SLEEP;
      endcase
   end

   // Reset lands in sleep, matching the state register reset value
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         state <= ST_SLEEP;
      else if (CE)
         state <= next_state;
   end

   // State bits stay high through the recessive wait
   assign sleep_state_bit = (state == ST_SLEEP) |
                            (state == ST_SLEEP_EXIT);
   assign init_state_bit = (state == ST_INIT) |
                           (state == ST_INIT_EXIT);
   assign SLEEP_MODE = sleep_state_bit;
   assign INIT_MODE = init_state_bit;
   assign enter_sleep = (next_state == ST_SLEEP) & (state != ST_SLEEP) &
                        (state != ST_SLEEP_EXIT);

   // ----------------------------------------------------------------
   // Error event detection
   // ----------------------------------------------------------------

   // Codes 0 and 7 mean no error and software-set, never an event
   assign code_hit = (ERR_CODE >= `CSMT_CODE_MIN) &
                     (ERR_CODE <= `CSMT_CODE_MAX);
   assign error_event = (BUS_OFF & bus_off_irq_en) |
                        (PASSIVE & passive_irq_en) |
                        (WARNING & warning_irq_en) |
                        (code_hit & error_code_irq_en);

   // ----------------------------------------------------------------
   // Sticky flags, write one to clear, set wins
   // ----------------------------------------------------------------
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         sleep_entered_flag <= 1'b0;
         wakeup_flag <= 1'b0;
         error_event_flag <= 1'b0;
      end
      else if (CE)
      begin
         if (enter_sleep)
            sleep_entered_flag <= 1'b1;
         else if (!sleep_state_bit)
            sleep_entered_flag <= 1'b0;
         else if (wr_state & WDATA[`CSMT_B_SLEEP_FLAG])
            sleep_entered_flag <= 1'b0;
         if (activity & (state == ST_SLEEP))
            wakeup_flag <= 1'b1;
         else if (wr_state & WDATA[`CSMT_B_WAKE_FLAG])
            wakeup_flag <= 1'b0;
         if (error_event)
            error_event_flag <= 1'b1;
         else if (wr_state & WDATA[`CSMT_B_ERR_FLAG])
            error_event_flag <= 1'b0;
      end
   end

   // Interrupt follows unmasked flags with no extra latency
   assign IRQ = |({sleep_entered_flag, wakeup_flag, error_event_flag} &
                  irq_mask);

   // ----------------------------------------------------------------
   // State register image
   // ----------------------------------------------------------------

   // Every bit not listed is a constant zero; writes cannot reach it
   assign state_word = {20'h00000,
                        rx_line_level,
                        rx_last_sample,
                        CORE_RX_ACTIVE,
                        CORE_TX_ACTIVE,
                        3'h0,
                        sleep_entered_flag,
                        wakeup_flag,
                        error_event_flag,
                        sleep_state_bit,
                        init_state_bit};

   // ----------------------------------------------------------------
   // Read port
   // ----------------------------------------------------------------

   // Data valid only the cycle after the strobe; unmapped reads give zero
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         RDATA <= 32'h00000000;
      else if (CE)
      begin
         RDATA <= 32'h00000000;
         if (RD)
         begin
            if (hit(ADDR, `CSMT_OFF_STATE))
               RDATA <= state_word;
            else if (hit(ADDR, `CSMT_OFF_MODE_CTL))
            begin
               RDATA[`CSMT_B_INIT_REQ] <= init_request;
               RDATA[`CSMT_B_SLEEP_REQ] <= sleep_request;
               RDATA[`CSMT_B_AUTO_WAKE] <= auto_wake_on_activity;
            end
            else if (hit(ADDR, `CSMT_OFF_IRQ_EN))
            begin
               RDATA[`CSMT_B_WARN_EN] <= warning_irq_en;
               RDATA[`CSMT_B_PASSIVE_EN] <= passive_irq_en;
               RDATA[`CSMT_B_BUSOFF_EN] <= bus_off_irq_en;
               RDATA[`CSMT_B_CODE_EN] <= error_code_irq_en;
            end
            else if (hit(ADDR, `CSMT_OFF_IRQ_MASK))
               RDATA[`CSMT_B_SLEEP_FLAG:`CSMT_B_ERR_FLAG] <= irq_mask;
         end
      end
   end

endmodule

//--- testbench/csmt_asserts.sv
`timescale 1ns/1ps
// ----------------
// Port checker
// ----------------
module csmt_asserts
(
   input wire CLK,            // Clock
   input wire RESET_N,        // Reset, active low
   input wire CE,             // Clock enable
   input wire [7:0] ADDR,     // Address
   input wire RD,             // Read strobe
   input wire [31:0] RDATA,   // Read data
   input wire RX_PIN,         // Receive pin
   input wire BIT_SAMPLE,     // Sample pulse
   input wire CORE_RX_ACTIVE, // Receiving
   input wire CORE_TX_ACTIVE, // Transmitting
   input wire INIT_MODE,      // Init state
   input wire SLEEP_MODE      // Sleep state
);
   reg [3:0] rec_cnt;
   reg [1:0] rx_dly;
   // Saturating run of recessive samples, seen through the sync delay;
   // an explicit two-flop delay keeps the clock of the history obvious
   always @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         rec_cnt <= 4'h0;
         rx_dly <= 2'b11;
      end
      else if (CE)
      begin
         rx_dly <= {rx_dly[0], RX_PIN};
         if (BIT_SAMPLE)
         begin
            if (!rx_dly[1])
               rec_cnt <= 4'h0;
            else if (rec_cnt != 4'hf)
               rec_cnt <= rec_cnt + 4'h1;
         end
      end
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   sequence s_state_rd;
      RD && CE && ADDR == 8'h04;
   endsequence
   sequence s_frame_busy;
      CORE_RX_ACTIVE || CORE_TX_ACTIVE;
   endsequence
   a_rd_receiving:
      assert property (s_state_rd |=> RDATA[9] == $past(CORE_RX_ACTIVE))
         else $error("receiving bit mismatch");
   a_rd_transmit:
      assert property (s_state_rd |=> RDATA[8] == $past(CORE_TX_ACTIVE))
         else $error("transmitting bit mismatch");
   a_rd_reserved_zero:
      assert property (s_state_rd |=> RDATA[31:12] == 0 && RDATA[7:5] == 0)
         else $error("reserved bits not zero");
   a_rdata_idle_zero:
      assert property (!RD && CE |=> RDATA == 32'h0)
         else $error("read data outside read cycle");
   a_rd_mode_bits:
      assert property (s_state_rd |=> RDATA[1:0] ==
         {$past(SLEEP_MODE), $past(INIT_MODE)})
         else $error("mode bits mismatch");
   a_sleep_after_frame:
      assert property (s_frame_busy ##0 !SLEEP_MODE && !INIT_MODE
         |=> !SLEEP_MODE) else $error("sleep entered in frame");
   a_init_after_frame:
      assert property (s_frame_busy ##0 !SLEEP_MODE && !INIT_MODE
         |=> !INIT_MODE) else $error("init entered in frame");
   a_sleep_exit_idle:
      assert property ($fell(SLEEP_MODE) && !INIT_MODE |-> rec_cnt >= 4'hb)
         else $error("sleep left too early");
   a_init_exit_idle:
      assert property ($fell(INIT_MODE) && !SLEEP_MODE |-> rec_cnt >= 4'hb)
         else $error("init left too early");
   a_sleep_flag_clear:
      assert property (s_state_rd ##0 !SLEEP_MODE && !$past(SLEEP_MODE)
         |=> !RDATA[4]) else $error("sleep flag stuck");
endmodule

//--- testbench/csmt_bus_model.sv
`timescale 1ns/1ps
// ----------------
// Bus and transceiver
// ----------------
module csmt_bus_model
#(
   parameter BIT_CYC = 10
)
(
   input wire clk,      // Clock
   input wire reset_n,  // Reset, active low
   input wire req_bit,  // Level the bench puts on the bus
   output reg rx_pin,   // Receive pin, pulled up when idle
   output reg bit_sample // One pulse in the middle of each bit
);
   integer cnt;
   // Bit changes at the boundary, sample half a bit later, so the
   // synchroniser has settled long before the sample point
   always @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cnt <= 0;
         rx_pin <= 1'b1;
         bit_sample <= 1'b0;
      end
      else
      begin
         cnt <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
         if (cnt == 0)
            rx_pin <= req_bit;
         bit_sample <= (cnt == BIT_CYC / 2);
      end
   end
endmodule

//--- testbench/csmt_top_bench.sv
`timescale 1ns/1ps
// ----------------
// Bench
// ----------------
module csmt_top_bench;
   reg CLK, RESET_N, CE, WR, RD, req_bit, CORE_RX_ACTIVE, CORE_TX_ACTIVE;
   reg BUS_OFF, PASSIVE, WARNING;
   reg [7:0] ADDR;
   reg [31:0] WDATA, d;
   reg [2:0] ERR_CODE;
   reg [3:0] en;
   reg e;
   wire [31:0] RDATA;
   wire IRQ, RX_PIN, BIT_SAMPLE, INIT_MODE, SLEEP_MODE;
   integer n_mismatch, checked, k;
   csmt_top DUT (.CLK(CLK), .RESET_N(RESET_N), .CE(CE), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
      .RX_PIN(RX_PIN), .BIT_SAMPLE(BIT_SAMPLE),
      .CORE_RX_ACTIVE(CORE_RX_ACTIVE), .CORE_TX_ACTIVE(CORE_TX_ACTIVE),
      .BUS_OFF(BUS_OFF), .PASSIVE(PASSIVE), .WARNING(WARNING),
      .ERR_CODE(ERR_CODE), .INIT_MODE(INIT_MODE), .SLEEP_MODE(SLEEP_MODE));
   csmt_bus_model #(.BIT_CYC(10)) u_bus (.clk(CLK), .reset_n(RESET_N),
      .req_bit(req_bit), .rx_pin(RX_PIN), .bit_sample(BIT_SAMPLE));
   // 50 ns clock
   initial
   begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end
   // Watchdog: a hang counts as a mismatch
   initial
   begin
      #4000000;
      n_mismatch = n_mismatch + 1;
      test_done;
   end
   task test_done;
   begin
      $display("checks %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
   begin
      checked = checked + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   end
   endtask
   // Whole-word accesses only, no byte lanes
   task wr(input [7:0] a, input [31:0] v);
   begin
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   end
   endtask
   task rd(input [7:0] a, output [31:0] q);
   begin
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 q = RDATA;
   end
   endtask
   // Waits for a mode pair; lim 0 checks at once
   task wait_mode(input s, input i, input integer lim);
      integer n;
   begin
      n = 0;
      #1;
      while ((SLEEP_MODE !== s || INIT_MODE !== i) && n < lim)
      begin
         @(posedge CLK);
         #1 n = n + 1;
      end
      chk({30'h0, SLEEP_MODE, INIT_MODE}, {30'h0, s, i});
      if ((SLEEP_MODE !== s || INIT_MODE !== i) && lim > 0)
         test_done;
   end
   endtask
   task wait_pulse;
      integer n;
   begin
      n = 0;
      do
      begin
         @(posedge CLK);
         n = n + 1;
      end while (BIT_SAMPLE !== 1'b1 && n < 40);
      if (n >= 40)
      begin
         n_mismatch = n_mismatch + 1;
         test_done;
      end
   end
   endtask
   // n bits of level v, counted at the sample points
   task bits(input v, input integer n);
   begin
      req_bit <= v;
      repeat (n) wait_pulse;
   end
   endtask
   function err_exp(input bo, input pa, input wa, input [2:0] c,
      input [3:0] m);
      err_exp = (bo & m[2]) | (pa & m[1]) | (wa & m[0]) |
         (m[3] & (c >= 3'h1) & (c <= 3'h6));
   endfunction
   // Main sequence
   initial
   begin
      RESET_N = 1'b0;
      CE = 1'b1;
      {WR, RD, ADDR, WDATA, req_bit} = {10'h0, 32'h0, 1'b1};
      {CORE_RX_ACTIVE, CORE_TX_ACTIVE, BUS_OFF, PASSIVE, WARNING} = 5'h0;
      ERR_CODE = 3'h0;
      n_mismatch = 0;
      checked = 0;
      k = $urandom(15752);
      repeat (12) @(posedge CLK);
      RESET_N <= 1'b1;
      rd(8'h04, d); chk(d, 32'h00000c02);
      rd(8'h00, d); chk(d, 32'h00000002);
      rd(8'h40, d); chk(d, 32'h00000000);
      // Wakeup by bus activity with auto wake
      wr(8'h00, 32'h00000022);
      bits(1'b0, 1);
      rd(8'h04, d); chk(d, 32'h0000000a);
      rd(8'h00, d); chk(d, 32'h00000020);
      bits(1'b1, 5);
      bits(1'b0, 1);
      bits(1'b1, 10); wait_mode(1'b1, 1'b0, 0);
      bits(1'b1, 1); wait_mode(1'b0, 1'b0, 8);
      wr(8'h04, 32'h00000008);
      rd(8'h04, d); chk(d, 32'h00000c00);
      // Sleep request during a frame, then exit by request drop
      @(posedge CLK) CORE_RX_ACTIVE <= 1'b1;
      wr(8'h00, 32'h00000002);
      repeat ($urandom_range(30, 5)) @(posedge CLK);
      wait_mode(1'b0, 1'b0, 0);
      rd(8'h04, d); chk(d, 32'h00000e00);
      @(posedge CLK) CORE_RX_ACTIVE <= 1'b0;
      wait_mode(1'b1, 1'b0, 8);
      rd(8'h04, d); chk(d, 32'h00000c12);
      wait_pulse;
      wr(8'h00, 32'h00000000);
      bits(1'b1, 10); wait_mode(1'b1, 1'b0, 0);
      bits(1'b1, 1); wait_mode(1'b0, 1'b0, 8);
      rd(8'h04, d); chk(d, 32'h00000c00);
      // Init request during a frame, then exit
      @(posedge CLK) CORE_TX_ACTIVE <= 1'b1;
      wr(8'h00, 32'h00000001);
      repeat (20) @(posedge CLK);
      wait_mode(1'b0, 1'b0, 0);
      rd(8'h04, d); chk(d, 32'h00000d00);
      @(posedge CLK) CORE_TX_ACTIVE <= 1'b0;
      wait_mode(1'b0, 1'b1, 8);
      rd(8'h04, d); chk(d, 32'h00000c01);
      wait_pulse;
      wr(8'h00, 32'h00000000);
      bits(1'b1, 10); wait_mode(1'b0, 1'b1, 0);
      bits(1'b1, 1); wait_mode(1'b0, 1'b0, 8);
      // Error sources, all codes, random enables
      wr(8'h18, 32'h0000001c);
      for (k = 0; k < 24; k = k + 1)
      begin
         // Enables first, so old enables never see the new sources
         en = $urandom_range(15, 0);
         wr(8'h14, {20'h0, en, 8'h0});
         {BUS_OFF, PASSIVE, WARNING} <= $urandom_range(7, 0);
         ERR_CODE <= (k < 8) ? k[2:0] : $urandom_range(7, 0);
         repeat (2) @(posedge CLK);
         e = err_exp(BUS_OFF, PASSIVE, WARNING, ERR_CODE, en);
         rd(8'h04, d); chk({31'h0, d[2]}, {31'h0, e});
         chk({31'h0, IRQ}, {31'h0, e});
         @(posedge CLK);
         {BUS_OFF, PASSIVE, WARNING, ERR_CODE} <= 6'h0;
         wr(8'h04, 32'h00000004);
         rd(8'h04, d); chk(d, 32'h00000c00);
      end
      // Mask gates the interrupt line
      @(posedge CLK) WARNING <= 1'b1;
      wr(8'h14, 32'h00000100);
      wr(8'h18, 32'h00000000);
      #1 chk({31'h0, IRQ}, 32'h0);
      wr(8'h18, 32'h00000004);
      #1 chk({31'h0, IRQ}, 32'h1);
      // Read-only and reserved bits ignore writes
      @(posedge CLK) WARNING <= 1'b0;
      wr(8'h04, 32'hffffffe7);
      rd(8'h04, d); chk(d, 32'h00000c00);
      wr(8'h40, 32'hffffffff);
      rd(8'h00, d); chk(d, 32'h00000000);
      // Clock enable low drops a write strobe
      @(posedge CLK) CE <= 1'b0;
      wr(8'h00, 32'h00000020);
      @(posedge CLK) CE <= 1'b1;
      rd(8'h00, d); chk(d, 32'h00000000);
      test_done;
   end
endmodule
bind csmt_top csmt_asserts u_chk (.CLK(CLK), .RESET_N(RESET_N), .CE(CE),
   .ADDR(ADDR), .RD(RD), .RDATA(RDATA), .RX_PIN(RX_PIN),
   .BIT_SAMPLE(BIT_SAMPLE), .CORE_RX_ACTIVE(CORE_RX_ACTIVE),
   .CORE_TX_ACTIVE(CORE_TX_ACTIVE), .INIT_MODE(INIT_MODE),
   .SLEEP_MODE(SLEEP_MODE));
